// File: rtl/dcl_regs.svh
`ifndef DCL_REGS_SVH
`define DCL_REGS_SVH

// register page numbers
`define DCL_PAGE_MAIN            3'h0
`define DCL_PAGE_MIRROR          3'h1

// fault flag register, main page
`define DCL_FLAGS_OFS            8'h0A
`define DCL_FLAG_TRIM_BIT        0
`define DCL_FLAG_FUSE_BIT        1
`define DCL_FLAG_STEST_BIT       2
`define DCL_FLAGS_RESET          3'h0

// loader status register, main page
`define DCL_STATUS_OFS           8'h0B

// mirror window on the extended page
`define DCL_MIRROR_BASE          8'hCC
`define DCL_MIRROR_LAST          8'hE3
`define DCL_MIRROR_DEPTH         24
`define DCL_MIRROR_RESET         8'h00

// mirror registers
`define DCL_BUCK5_FUSE_CFG_A     8'hCC
`define DCL_BUCK5_FUSE_CFG_B     8'hCD
`define DCL_LDO1_VOLT_THR        8'hCE
`define DCL_LDO1_POWER_UP_REQUEST_SEQ       8'hCF
`define DCL_LDO1_FUSE_CFG        8'hD0
`define DCL_LDO2_VOLT_THR        8'hD1
`define DCL_LDO2_POWER_UP_REQUEST_SEQ       8'hD2
`define DCL_LDO2_FUSE_CFG        8'hD3
`define DCL_STBY_RAIL_VOLT_CFG   8'hDA
`define DCL_OV_BYPASS_BUCKS      8'hDB
`define DCL_OV_BYPASS_LINEARS    8'hDC
`define DCL_UV_BYPASS_BUCKS      8'hDD
`define DCL_UV_BYPASS_LINEARS    8'hDE
`define DCL_ILIM_BYPASS_BUCKS    8'hDF
`define DCL_ILIM_BYPASS_LINEARS  8'hE0
`define DCL_PROG_TAG_HIGH        8'hE1
`define DCL_PROG_TAG_LOW         8'hE2
`define DCL_FUSE_DEBUG_OPTS      8'hE3

`endif

// File: rtl/dcl_pkg.sv
package dcl_pkg;

    typedef enum logic [2:0] {
        ST_UNPOWERED = 3'b000,
        ST_TRIM      = 3'b001,
        ST_FUSE      = 3'b010,
        ST_XFER      = 3'b011,
        ST_TEST      = 3'b100,
        ST_QOFF      = 3'b101,
        ST_ON        = 3'b110
    } dcl_state_t;

    typedef struct packed {
        logic       stest;
        logic       fuse;
        logic       trim;
    } dcl_flags_t;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } dcl_func_wr_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dcl_reg_req_t;

endpackage

// File: rtl/dcl_mirror.sv
`timescale 1ns/100ps
`default_nettype none
`include "dcl_regs.svh"

module dcl_mirror #(
    parameter int DEPTH = `DCL_MIRROR_DEPTH
) (
    input  wire logic                     ref_clk,
    input  wire logic                     reset_n,
    input  wire logic                     clear,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input  wire logic [7:0]               wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic      [7:0]               rd_data
);
    logic [7:0] mem_r [DEPTH];

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= `DCL_MIRROR_RESET;
            end
        end else if (clear) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= `DCL_MIRROR_RESET;
            end
        end else if (wr_en) begin
            mem_r[wr_idx] <= wr_data;
        end
    end

    assign rd_data = mem_r[rd_idx];

endmodule
`default_nettype wire

// File: rtl/dcl_loader.sv
// Summary of operation
// - the source select pin is sampled at the start of every load.
// - with the select pin at ground the registers load from the mirror.
// - with the select pin at the 1.5 V rail they come from the hardwire image.
// - on the fuse source each supply rise copies the fuses into the mirror.
// - the second stage copies the mirror into the functional registers.
// - the mirror holds the defaults and is writable only in trial mode.
// - the hardwire source reloads from the image and forbids trial mode.
// - a trim, fuse or self-test failure sets its flag and blocks power-up.
// - the flags are writable only while the trial enable pin is high.
// - with the trial enable pin low the flags are read-only.
// - trial mode ignores the low-power-off bit and stops in quiescent off.
// - in trial mode the self-test result lands in its flag, 0 pass, 1 fail.
// - a power-up with the trial pin high runs with limited function.
// - a supply drop below threshold resets the mirror.
// - trial mode maps the mirror to page 1; else extended pages are refused.
`timescale 1ns/100ps
`default_nettype none
`include "dcl_regs.svh"

module dcl_loader #(
    parameter int                      DEPTH    = `DCL_MIRROR_DEPTH,
    parameter logic [DEPTH*8-1:0]      HW_IMAGE = '0
) (
    input  wire logic                  ref_clk,
    input  wire logic                  reset_n,
    input  wire logic                  config_source_select_pin,
    input  wire logic                  trial_enable_pin,
    input  wire logic                  input_supply_ok_pin,
    input  wire logic                  power_up_request_pin,
    input  wire logic                  low_power_off_bit,
    input  wire dcl_pkg::dcl_reg_req_t reg_req,
    output logic      [7:0]            reg_rdata,
    output logic                       reg_refused,
    output logic                       trim_req,
    input  wire logic                  trim_ack,
    input  wire logic                  trim_fail,
    output logic                       fuse_req,
    output logic      [7:0]            fuse_addr,
    input  wire logic                  fuse_ack,
    input  wire logic [7:0]            fuse_data,
    input  wire logic                  fuse_fail,
    output logic                       stest_req,
    input  wire logic                  stest_ack,
    input  wire logic                  stest_fail,
    output dcl_pkg::dcl_func_wr_t      func_wr,
    output dcl_pkg::dcl_flags_t        fault_flags,
    output logic                       quiescent_off_state,
    output logic                       powered_on,
    output logic                       limited_function,
    output logic                       trial_configuration_mode
);
    localparam int IW = $clog2(DEPTH);
    localparam logic [IW-1:0] LAST_IDX = IW'(DEPTH - 1);

    function automatic logic mirror_hit(input logic [7:0] a);
        mirror_hit = (a >= `DCL_MIRROR_BASE) && (a <= `DCL_MIRROR_LAST);
    endfunction

    function automatic logic [IW-1:0] mirror_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - `DCL_MIRROR_BASE;
        mirror_idx = d[IW-1:0];
    endfunction

    function automatic logic [7:0] idx_addr(input logic [IW-1:0] i);
        idx_addr = `DCL_MIRROR_BASE + 8'(i);
    endfunction

    // pin synchronisers: select, trial, supply, power-up
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic       uv_prev_r;
    logic       pu_prev_r;
    logic       src_sel_s;
    logic       trial_pin_s;
    logic       uv_ok_s;
    logic       pu_s;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
        end else begin
            sync1_r <= {power_up_request_pin, input_supply_ok_pin,
                        trial_enable_pin, config_source_select_pin};
            sync2_r <= sync1_r;
        end
    end

    assign src_sel_s   = sync2_r[0];
    assign trial_pin_s = sync2_r[1];
    assign uv_ok_s     = sync2_r[2];
    assign pu_s        = sync2_r[3];

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            uv_prev_r <= 1'b0;
            pu_prev_r <= 1'b0;
        end else begin
            uv_prev_r <= uv_ok_s;
            pu_prev_r <= pu_s;
        end
    end

    logic uv_rise;
    logic uv_lost;
    logic pu_event;
    assign uv_rise  = uv_ok_s && !uv_prev_r;
    assign uv_lost  = !uv_ok_s;
    assign pu_event = pu_s && !pu_prev_r;

    dcl_pkg::dcl_state_t state_r;
    dcl_pkg::dcl_state_t state_nxt;
    logic                src_hw_r;
    logic [IW-1:0]       idx_r;
    logic                fuse_req_r;
    logic                trim_req_r;
    logic                stest_req_r;
    dcl_pkg::dcl_flags_t flags_r;
    logic                trial_mode;
    logic                flags_set_any;

    // trial mode exists only on the fuse source
    assign trial_mode    = trial_pin_s && !src_hw_r;
    assign flags_set_any = flags_r.trim || flags_r.fuse || flags_r.stest;

    // register access decode
    logic          wr_mirror;
    logic          wr_flags;
    logic          ext_page;
    logic [7:0]    mirror_rd;
    logic [IW-1:0] mirror_rd_idx;
    logic          m_wr;
    logic [IW-1:0] m_wr_idx;
    logic [7:0]    m_wr_data;

    assign ext_page  = reg_req.page != `DCL_PAGE_MAIN;
    assign wr_mirror = reg_req.wr && trial_mode
                       && reg_req.page == `DCL_PAGE_MIRROR
                       && mirror_hit(reg_req.addr);
    assign wr_flags  = reg_req.wr && !ext_page
                       && reg_req.addr == `DCL_FLAGS_OFS
                       && trial_pin_s
                       && state_r == dcl_pkg::ST_QOFF;

    // stage one writes fuses, otherwise software edits in trial mode
    always_comb begin
        m_wr      = 1'b0;
        m_wr_idx  = idx_r;
        m_wr_data = fuse_data;
        if (state_r == dcl_pkg::ST_FUSE && fuse_req_r && fuse_ack) begin
            m_wr = 1'b1;
        end else if (wr_mirror) begin
            m_wr      = 1'b1;
            m_wr_idx  = mirror_idx(reg_req.addr);
            m_wr_data = reg_req.wdata;
        end
    end

    assign mirror_rd_idx = (state_r == dcl_pkg::ST_XFER) ? idx_r
                           : mirror_idx(reg_req.addr);

    dcl_mirror #(
        .DEPTH   (DEPTH)
    ) u_mirror (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .clear   (uv_lost),
        .wr_en   (m_wr),
        .wr_idx  (m_wr_idx),
        .wr_data (m_wr_data),
        .rd_idx  (mirror_rd_idx),
        .rd_data (mirror_rd)
    );

    // sequencer
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            dcl_pkg::ST_UNPOWERED: begin
                if (uv_rise) begin
                    state_nxt = dcl_pkg::ST_TRIM;
                end
            end
            dcl_pkg::ST_TRIM: begin
                if (trim_req_r && trim_ack) begin
                    state_nxt = src_hw_r ? dcl_pkg::ST_XFER
                                         : dcl_pkg::ST_FUSE;
                end
            end
            dcl_pkg::ST_FUSE: begin
                if (fuse_req_r && fuse_ack && idx_r == LAST_IDX) begin
                    state_nxt = dcl_pkg::ST_XFER;
                end
            end
            dcl_pkg::ST_XFER: begin
                if (idx_r == LAST_IDX) begin
                    state_nxt = dcl_pkg::ST_TEST;
                end
            end
            dcl_pkg::ST_TEST: begin
                if (stest_req_r && stest_ack) begin
                    if (trial_pin_s || stest_fail || low_power_off_bit
                        || flags_set_any) begin
                        state_nxt = dcl_pkg::ST_QOFF;
                    end else begin
                        state_nxt = dcl_pkg::ST_ON;
                    end
                end
            end
            dcl_pkg::ST_QOFF: begin
                if (pu_event && !flags_set_any) begin
                    state_nxt = dcl_pkg::ST_ON;
                end
            end
            dcl_pkg::ST_ON: begin
                state_nxt = dcl_pkg::ST_ON;
            end
            default: begin
                state_nxt = dcl_pkg::ST_UNPOWERED;
            end
        endcase
        if (uv_lost) begin
            state_nxt = dcl_pkg::ST_UNPOWERED;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= dcl_pkg::ST_UNPOWERED;
        end else begin
            state_r <= state_nxt;
        end
    end

    // source is latched once per load
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            src_hw_r <= 1'b0;
        end else if (state_r == dcl_pkg::ST_UNPOWERED && uv_rise) begin
            src_hw_r <= src_sel_s;
        end
    end

    // walking index for fuse copy and transfer
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            idx_r <= '0;
        end else if (state_r != state_nxt) begin
            idx_r <= '0;
        end else if (state_r == dcl_pkg::ST_FUSE && fuse_req_r
                     && fuse_ack) begin
            idx_r <= idx_r + 1'b1;
        end else if (state_r == dcl_pkg::ST_XFER) begin
            idx_r <= idx_r + 1'b1;
        end
    end

    // trim, fuse and self-test handshakes: request held until ack
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            trim_req_r <= 1'b0;
        end else begin
            trim_req_r <= state_nxt == dcl_pkg::ST_TRIM
                          && !(trim_req_r && trim_ack);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fuse_req_r <= 1'b0;
            fuse_addr  <= 8'h00;
        end else begin
            fuse_req_r <= state_nxt == dcl_pkg::ST_FUSE
                          && !(fuse_req_r && fuse_ack);
            if (state_r != dcl_pkg::ST_FUSE) begin
                fuse_addr <= `DCL_MIRROR_BASE;
            end else if (fuse_req_r && fuse_ack) begin
                fuse_addr <= fuse_addr + 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            stest_req_r <= 1'b0;
        end else begin
            stest_req_r <= state_nxt == dcl_pkg::ST_TEST
                           && !(stest_req_r && stest_ack);
        end
    end

    assign trim_req  = trim_req_r;
    assign fuse_req  = fuse_req_r;
    assign stest_req = stest_req_r;

    // stage two: one functional write per cycle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            func_wr <= '0;
        end else begin
            func_wr.wr   <= state_r == dcl_pkg::ST_XFER && !uv_lost;
            func_wr.addr <= idx_addr(idx_r);
            func_wr.data <= src_hw_r ? HW_IMAGE[8*idx_r +: 8]
                                     : mirror_rd;
        end
    end

    // fault flags: a hardware set beats a software clear
    dcl_pkg::dcl_flags_t set_v;
    dcl_pkg::dcl_flags_t clr_v;

    always_comb begin
        set_v       = '0;
        clr_v       = '0;
        set_v.trim  = state_r == dcl_pkg::ST_TRIM && trim_req_r
                      && trim_ack && trim_fail;
        set_v.fuse  = state_r == dcl_pkg::ST_FUSE && fuse_req_r
                      && fuse_ack && fuse_fail;
        set_v.stest = state_r == dcl_pkg::ST_TEST && stest_req_r
                      && stest_ack && stest_fail;
        if (wr_flags) begin
            clr_v.trim  = reg_req.wdata[`DCL_FLAG_TRIM_BIT];
            clr_v.fuse  = reg_req.wdata[`DCL_FLAG_FUSE_BIT];
            clr_v.stest = reg_req.wdata[`DCL_FLAG_STEST_BIT];
        end
        if (state_r == dcl_pkg::ST_TEST && stest_req_r && stest_ack
            && !stest_fail) begin
            clr_v.stest = 1'b1;
        end
        if (state_r == dcl_pkg::ST_TRIM && src_hw_r) begin
            clr_v.fuse = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_r <= `DCL_FLAGS_RESET;
        end else begin
            flags_r <= set_v | (flags_r & ~clr_v);
        end
    end

    assign fault_flags = flags_r;

    // register read port, answered one cycle after the strobe
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata   <= 8'h00;
            reg_refused <= 1'b0;
        end else begin
            reg_refused <= (reg_req.rd || reg_req.wr) && ext_page
                           && !(trial_mode
                                && reg_req.page == `DCL_PAGE_MIRROR);
            if (reg_req.rd) begin
                reg_rdata <= 8'h00;
                if (ext_page) begin
                    if (trial_mode && reg_req.page == `DCL_PAGE_MIRROR
                        && mirror_hit(reg_req.addr)) begin
                        reg_rdata <= mirror_rd;
                    end
                end else if (reg_req.addr == `DCL_FLAGS_OFS) begin
                    reg_rdata <= {5'h00, flags_r};
                end else if (reg_req.addr == `DCL_STATUS_OFS) begin
                    reg_rdata <= {3'h0, trial_mode, src_hw_r, state_r};
                end
            end
        end
    end

    // mode and power state outputs
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            quiescent_off_state      <= 1'b0;
            powered_on               <= 1'b0;
            trial_configuration_mode <= 1'b0;
        end else begin
            quiescent_off_state      <= state_nxt == dcl_pkg::ST_QOFF;
            powered_on               <= state_nxt == dcl_pkg::ST_ON;
            trial_configuration_mode <= trial_mode;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            limited_function <= 1'b0;
        end else if (state_r != dcl_pkg::ST_ON
                     && state_nxt == dcl_pkg::ST_ON) begin
            limited_function <= trial_pin_s;
        end else if (state_nxt != dcl_pkg::ST_ON) begin
            limited_function <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// File: testbench/dcl_loader_sva.sv
`timescale 1ns/100ps
`default_nettype none

module dcl_loader_sva (
    input  wire logic                  ref_clk,
    input  wire logic                  reset_n,
    input  wire dcl_pkg::dcl_reg_req_t reg_req,
    input  wire logic                  reg_refused,
    input  wire logic                  trim_req,
    input  wire logic                  trim_ack,
    input  wire logic                  fuse_req,
    input  wire logic [7:0]            fuse_addr,
    input  wire logic                  fuse_ack,
    input  wire logic                  stest_req,
    input  wire logic                  stest_ack,
    input  wire logic                  stest_fail,
    input  wire logic                  low_power_off_bit,
    input  wire dcl_pkg::dcl_func_wr_t func_wr,
    input  wire dcl_pkg::dcl_flags_t   fault_flags,
    input  wire logic                  quiescent_off_state,
    input  wire logic                  powered_on,
    input  wire logic                  trial_configuration_mode
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence trim_wait_s;
        trim_req && !trim_ack;
    endsequence
    sequence burst_step_s;
        func_wr.wr && func_wr.addr != 8'hE3;
    endsequence
    sequence test_done_s;
        stest_req && stest_ack;
    endsequence

    trim_hold_a: assert property (trim_wait_s |=> trim_req)
        else $error("trim request dropped");
    trim_release_a: assert property (trim_req && trim_ack |=> !trim_req)
        else $error("trim request held");
    fuse_step_a: assert property (fuse_req && fuse_ack
        && fuse_addr != 8'hE3 |=> fuse_addr == $past(fuse_addr) + 8'h01)
        else $error("fuse address skipped");
    burst_start_a: assert property ($rose(func_wr.wr)
        |-> func_wr.addr == 8'hCC)
        else $error("burst start wrong");
    burst_step_a: assert property (burst_step_s
        |=> func_wr.wr && func_wr.addr == $past(func_wr.addr) + 8'h01)
        else $error("burst broken");
    stop_quiet_a: assert property (test_done_s ##0
        (trial_configuration_mode || low_power_off_bit || stest_fail)
        |=> quiescent_off_state && !powered_on)
        else $error("no quiescent off");
    test_flag_a: assert property (test_done_s
        |=> fault_flags.stest == $past(stest_fail))
        else $error("self-test flag wrong");
    power_gate_a: assert property ($rose(powered_on)
        |-> fault_flags == 3'h0
        && ($past(quiescent_off_state) || $past(stest_ack)))
        else $error("early power-up");
    page_refuse_a: assert property ((reg_req.rd || reg_req.wr)
        && reg_req.page != 3'h0 && !trial_configuration_mode
        |=> reg_refused)
        else $error("page not refused");
    page_main_a: assert property ((reg_req.rd || reg_req.wr)
        && reg_req.page == 3'h0 |=> !reg_refused)
        else $error("main page refused");
endmodule

bind dcl_loader dcl_loader_sva i_dcl_loader_sva (
    .ref_clk, .reset_n, .reg_req, .reg_refused, .trim_req, .trim_ack,
    .fuse_req, .fuse_addr, .fuse_ack, .stest_req, .stest_ack, .stest_fail,
    .low_power_off_bit, .func_wr, .fault_flags, .quiescent_off_state,
    .powered_on, .trial_configuration_mode
);

`default_nettype wire

// File: testbench/dcl_fuse_model.sv
`timescale 1ns/100ps
`default_nettype none

module dcl_fuse_model (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       trim_req,
    input  wire logic       fuse_req,
    input  wire logic [7:0] fuse_addr,
    input  wire logic       stest_req,
    input  wire logic       slow,
    input  wire logic [2:0] bad,
    output logic            trim_ack,
    output logic            trim_fail,
    output logic            fuse_ack,
    output logic            fuse_fail,
    output logic [7:0]      fuse_data,
    output logic            stest_ack,
    output logic            stest_fail
);
    logic [1:0] wait_r;
    logic       busy;
    logic       go;

    assign busy = trim_ack | fuse_ack | stest_ack;
    assign go = !busy && (trim_req | fuse_req | stest_req)
                && wait_r == (slow ? 2'h3 : 2'h0);
    assign trim_fail = trim_ack & bad[0];
    assign fuse_fail = fuse_ack & bad[1];
    assign stest_fail = stest_ack & bad[2];

    // fuse byte is addr^3c while answered, scrambled otherwise
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_r <= 2'h0;
            trim_ack <= 1'b0;
            fuse_ack <= 1'b0;
            stest_ack <= 1'b0;
            fuse_data <= 8'h00;
        end else begin
            wait_r <= (go || busy) ? 2'h0 : wait_r + 2'h1;
            trim_ack <= go && trim_req;
            fuse_ack <= go && fuse_req && !trim_req;
            stest_ack <= go && stest_req && !trim_req && !fuse_req;
            fuse_data <= (go && fuse_req) ? (fuse_addr ^ 8'h3C) : ~fuse_data;
        end
    end
endmodule

`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
    localparam logic [191:0] HW_IMAGE = {24{8'hA7}};
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic config_source_select_pin = 1'b0;
    logic trial_enable_pin = 1'b0;
    logic input_supply_ok_pin = 1'b0;
    logic power_up_request_pin = 1'b0;
    logic low_power_off_bit = 1'b0;
    logic slow = 1'b0;
    logic [2:0] bad = 3'h0;
    dcl_pkg::dcl_reg_req_t reg_req = '0;
    dcl_pkg::dcl_func_wr_t func_wr;
    dcl_pkg::dcl_flags_t fault_flags;
    logic [7:0] reg_rdata, fuse_addr, fuse_data, a, fw [0:255];
    logic reg_refused, trim_req, trim_ack, trim_fail, fuse_req, fuse_ack;
    logic fuse_fail, stest_req, stest_ack, stest_fail, refused;
    logic quiescent_off_state, powered_on, limited_function;
    logic trial_configuration_mode;
    int nwr, miscompares, checks, k;
    // power status: qoff, trial, on, limited
    wire [7:0] pst = {4'h0, quiescent_off_state,
                      trial_configuration_mode, powered_on, limited_function};

    dcl_loader #(.DEPTH(24), .HW_IMAGE(HW_IMAGE)) i_dcl_loader (
        .ref_clk, .reset_n, .config_source_select_pin, .trial_enable_pin,
        .input_supply_ok_pin, .power_up_request_pin, .low_power_off_bit,
        .reg_req, .reg_rdata, .reg_refused, .trim_req, .trim_ack,
        .trim_fail, .fuse_req, .fuse_addr, .fuse_ack, .fuse_data,
        .fuse_fail, .stest_req, .stest_ack, .stest_fail, .func_wr,
        .fault_flags, .quiescent_off_state, .powered_on, .limited_function,
        .trial_configuration_mode
    );

    dcl_fuse_model i_dcl_fuse_model (
        .ref_clk, .reset_n, .trim_req, .fuse_req, .fuse_addr, .stest_req,
        .slow, .bad, .trim_ack, .trim_fail, .fuse_ack, .fuse_fail,
        .fuse_data, .stest_ack, .stest_fail
    );

    always #50 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        if (func_wr.wr === 1'b1) begin
            fw[func_wr.addr] = func_wr.data;
            nwr++;
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic reg_acc(input logic wr, input logic [2:0] page,
                           input logic [7:0] addr, input logic [7:0] wdata);
        @(negedge ref_clk);
        reg_req = {wr, ~wr, page, addr, wdata};
        @(negedge ref_clk);
        refused = reg_refused;
        reg_req = '0;
        @(negedge ref_clk);
        refused = refused | reg_refused;
    endtask

    task automatic power_cycle(input logic src, input logic trial);
        int n;
        @(negedge ref_clk);
        input_supply_ok_pin = 1'b0;
        config_source_select_pin = src;
        trial_enable_pin = trial;
        repeat (10) @(negedge ref_clk);
        nwr = 0;
        input_supply_ok_pin = 1'b1;
        n = 0;
        while (!(quiescent_off_state === 1'b1 || powered_on === 1'b1)) begin
            @(negedge ref_clk);
            n++;
            if (n > 3000) begin
                miscompares++;
                tally_and_finish();
            end
        end
    endtask

    task automatic pwr_req();
        @(negedge ref_clk);
        power_up_request_pin = 1'b1;
        repeat (4) @(negedge ref_clk);
        power_up_request_pin = 1'b0;
        repeat (6) @(negedge ref_clk);
    endtask

    initial begin
        repeat (5) @(negedge ref_clk);
        reset_n = 1'b1;
        slow = 1'b1;
        power_cycle(1'b0, 1'b0);
        check(pst, 8'h02);
        check(nwr[7:0], 8'h18);
        for (a = 8'hCC; a <= 8'hE3; a++) begin
            check(fw[a], a ^ 8'h3C);
        end
        reg_acc(1'b0, 3'h1, 8'hCF, 8'h00);
        check({7'h00, refused}, 8'h01);
        check(reg_rdata, 8'h00);
        reg_acc(1'b0, 3'h0, 8'h0B, 8'h00);
        check(reg_rdata, 8'h06);
        slow = 1'b0;
        power_cycle(1'b0, 1'b1);
        check(pst, 8'h0C);
        reg_acc(1'b0, 3'h1, 8'hCF, 8'h00);
        check(reg_rdata, 8'hF3);
        reg_acc(1'b1, 3'h1, 8'hCF, 8'h5A);
        reg_acc(1'b0, 3'h1, 8'hCF, 8'h00);
        check(reg_rdata, 8'h5A);
        pwr_req();
        check(pst, 8'h07);
        power_cycle(1'b0, 1'b1);
        reg_acc(1'b0, 3'h1, 8'hCF, 8'h00);
        check(reg_rdata, 8'hF3);
        for (k = 0; k < 3; k++) begin
            bad = 3'h1 << k;
            power_cycle(1'b0, 1'b1);
            bad = 3'h0;
            reg_acc(1'b0, 3'h0, 8'h0A, 8'h00);
            check(reg_rdata, 8'h01 << k);
            pwr_req();
            check(pst, 8'h0C);
            trial_enable_pin = 1'b0;
            repeat (4) @(negedge ref_clk);
            reg_acc(1'b1, 3'h0, 8'h0A, 8'h07);
            reg_acc(1'b0, 3'h0, 8'h0A, 8'h00);
            check(reg_rdata, 8'h01 << k);
            trial_enable_pin = 1'b1;
            repeat (4) @(negedge ref_clk);
            reg_acc(1'b1, 3'h0, 8'h0A, 8'h07);
            reg_acc(1'b0, 3'h0, 8'h0A, 8'h00);
            check(reg_rdata, 8'h00);
            pwr_req();
            check(pst, 8'h07);
        end
        power_cycle(1'b1, 1'b1);
        check(pst, 8'h08);
        for (a = 8'hCC; a <= 8'hE3; a++) begin
            check(fw[a], 8'hA7);
        end
        reg_acc(1'b0, 3'h1, 8'hCF, 8'h00);
        check({7'h00, refused}, 8'h01);
        reg_acc(1'b0, 3'h0, 8'h0B, 8'h00);
        check(reg_rdata & 8'h18, 8'h08);
        low_power_off_bit = 1'b1;
        power_cycle(1'b0, 1'b0);
        check(fw[8'hCF], 8'hF3);
        check(pst, 8'h08);
        pwr_req();
        check(pst, 8'h02);
        tally_and_finish();
    end
endmodule

`default_nettype wire
